/* include/fsps_defs.svh */
// Register addresses, field positions, key values and sequence constants
// How it works
// - Host loads high compare with the same block number as high pointer.
// - Host loads low compare with the last address to verify.
// - Host keeps upper four bits of high pointer and high compare zero.
// - Low compare is zero for block erase, all ones for blank check.
// - Enter mode: key, 01H, FEH, 01H; only the last write is taken.
// - Leave mode: key, 00H, FFH, 00H; only the last write is taken.
// - Host masks all interrupts and disables them before entering the mode; this host writes FFH to both mask registers and does not disable interrupts.
// - Host clears status before a switch and retries while the error bit is set; this host stops after MAX_RETRY attempts.
// - Host restores interrupt masks and enables interrupts after leaving; this host writes 00H to both mask registers.
// - Host runs switch sequences only from code that is not being changed.
// - Host enters self-programming mode before issuing any command; this host does not check the mode before a command op.
// - The operation starts when the CPU halts and resumes after it ends.
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// Device register addresses
`define FSPS_DEV_KEY_ADDR 16'hFFA0
`define FSPS_DEV_STATUS_ADDR 16'hFFA1
`define FSPS_DEV_MODE_ADDR 16'hFFA2
`define FSPS_DEV_CMD_ADDR 16'hFFA3
`define FSPS_DEV_PTRH_ADDR 16'hFFA4
`define FSPS_DEV_PTRL_ADDR 16'hFFA5
`define FSPS_DEV_CMPH_ADDR 16'hFFA6
`define FSPS_DEV_CMPL_ADDR 16'hFFA7
`define FSPS_DEV_WBUF_ADDR 16'hFFA8
`define FSPS_DEV_MASK0_ADDR 16'hFFE4
`define FSPS_DEV_MASK1_ADDR 16'hFFE5

// Values
`define FSPS_KEY_VAL 8'hA5
`define FSPS_MODE_SELF 8'h01
`define FSPS_MODE_NORMAL 8'h00
`define FSPS_ALL_ONES 8'hFF
`define FSPS_ZERO 8'h00
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_BLANK 8'h04
`define FSPS_CMD_WRITE 8'h05
`define FSPS_CMD_VERIFY 8'h01
`define FSPS_HIGH_NIBBLE_MASK 8'h0F
`define FSPS_STAT_SEQ_BIT 0
`define FSPS_STAT_VC_BIT 1
`define FSPS_STAT_WE_BIT 2
`define FSPS_PROT_SEL_LSB 2
`define FSPS_PROT_SEL_MSB 6
`define FSPS_PROT_NONE 5'h1F
`define FSPS_PROT8_BASE 5'h0C
`define FSPS_PROT16_BASE 5'h08

// Host register offsets on Wishbone (byte addresses)
`define FSPS_WB_CTRL 4'h0
`define FSPS_WB_STATUS 4'h1
`define FSPS_WB_BLOCK 4'h2
`define FSPS_WB_LOW 4'h3
`define FSPS_WB_LAST 4'h4
`define FSPS_WB_DATA 4'h5
`define FSPS_WB_PROT 4'h6
`define FSPS_WB_RESULT 4'h7

// Control register fields
`define FSPS_CTRL_GO_BIT 0
`define FSPS_CTRL_OP_LSB 1
`define FSPS_CTRL_OP_MSB 3
`define FSPS_CTRL_BIG_BIT 4

// Retry limit for the switch sequence
`define FSPS_MAX_RETRY 8'h08

`endif

/* include/fsps_pkg.sv */
// Types for the flash self-programming host controller
package fsps_pkg;
	typedef enum logic [2:0] {
		FSPS_OP_ENTER,
		FSPS_OP_LEAVE,
		FSPS_OP_ERASE,
		FSPS_OP_BLANK,
		FSPS_OP_WRITE,
		FSPS_OP_VERIFY
	} fsps_op_t;

	typedef enum logic [4:0] {
		FSPS_IDLE,
		FSPS_MASK0,
		FSPS_MASK1,
		FSPS_CLR,
		FSPS_KEY,
		FSPS_MODE1,
		FSPS_MODEC,
		FSPS_MODE2,
		FSPS_CHECK,
		FSPS_RESTORE0,
		FSPS_RESTORE1,
		FSPS_CMD,
		FSPS_PTRH,
		FSPS_PTRL,
		FSPS_CMPH,
		FSPS_CMPL,
		FSPS_WBUF,
		FSPS_CLR2,
		FSPS_HALT,
		FSPS_WAITDONE,
		FSPS_READRES,
		FSPS_DONE
	} fsps_state_t;
endpackage

/* rtl/fsps_devport.sv */
// Single device-bus access engine: one write or read per request
`timescale 1ns/1ps
module fsps_devport (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic done_o,
	output logic [7:0] rdata_o,
	output logic dev_we_o,
	output logic dev_re_o,
	output logic [15:0] dev_addr_o,
	output logic [7:0] dev_wdata_o,
	input wire logic [7:0] dev_rdata_i
);
	logic busy_r;

	// Drive one strobe cycle, capture read data in the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			done_o <= 1'b0;
			dev_we_o <= 1'b0;
			dev_re_o <= 1'b0;
			dev_addr_o <= 16'h0000;
			dev_wdata_o <= 8'h00;
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			done_o <= 1'b0;
			dev_we_o <= 1'b0;
			dev_re_o <= 1'b0;
			if (req_i && !busy_r && !done_o) begin
				busy_r <= 1'b1;
				dev_we_o <= we_i;
				dev_re_o <= !we_i;
				dev_addr_o <= addr_i;
				dev_wdata_o <= wdata_i;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				done_o <= 1'b1;
				rdata_o <= dev_rdata_i; // Read data stands with the strobe, taken at its end
			end
		end
	end
endmodule // fsps_devport

/* rtl/fsps_host.sv */
// Host controller that drives the flash self-programming unit's registers
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "fsps_defs.svh"
module fsps_host #(
	parameter int MAX_RETRY = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic wb_sel_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	// Device register port
	output logic dev_we_o,
	output logic dev_re_o,
	output logic [15:0] dev_addr_o,
	output logic [7:0] dev_wdata_o,
	input wire logic [7:0] dev_rdata_i,
	// Halt request and completion from the CPU side, and busy flag
	output logic halt_req_o,
	input wire logic halt_done_i,
	output logic busy_o
);
	import fsps_pkg::*;

	fsps_state_t state_r;
	fsps_op_t op_r;
	logic big_r;
	logic [7:0] block_r;
	logic [7:0] low_r;
	logic [7:0] last_r;
	logic [7:0] data_r;
	logic [7:0] prot_r;
	logic [7:0] result_r;
	logic [7:0] retry_r;
	logic seq_fail_r;
	logic prot_hit_r;
	logic done_r;
	logic go;
	logic wb_hit;
	logic acc_req;
	logic acc_we;
	logic [15:0] acc_addr;
	logic [7:0] acc_wdata;
	logic acc_done;
	logic [7:0] acc_rdata;
	logic [7:0] mode_val;

	// Block protected by the select code; prohibited codes protect all
	function automatic logic blk_protected(input logic [7:0] pb, input logic [7:0] blk,
		input logic big);
		logic [4:0] sel;
		logic [4:0] top;
		sel = pb[`FSPS_PROT_SEL_MSB:`FSPS_PROT_SEL_LSB];
		top = 5'h00;
		blk_protected = 1'b1;
		if (sel == `FSPS_PROT_NONE) begin
			blk_protected = 1'b0;
		end else if (!big && sel >= `FSPS_PROT8_BASE && sel <= 5'h0F) begin
			top = 5'(5'h07 - 5'((sel - `FSPS_PROT8_BASE) << 1));
			blk_protected = (blk[4:0] <= top);
		end else if (big && sel >= `FSPS_PROT16_BASE && sel <= 5'h0F) begin
			top = 5'(5'h0F - 5'((sel - `FSPS_PROT16_BASE) << 1));
			blk_protected = (blk[4:0] <= top);
		end
	endfunction

	assign wb_hit = wb_cyc_i && wb_stb_i;
	assign go = wb_hit && wb_we_i && wb_sel_i && !wb_ack_o &&
		wb_adr_i == `FSPS_WB_CTRL && wb_dat_i[`FSPS_CTRL_GO_BIT] && state_r == FSPS_IDLE;
	assign busy_o = (state_r != FSPS_IDLE);
	assign mode_val = (op_r == FSPS_OP_ENTER) ? `FSPS_MODE_SELF : `FSPS_MODE_NORMAL;

	// Wishbone ack one cycle after the request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= wb_hit && !wb_ack_o;
		end
	end

	// Software-written parameter registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			block_r <= 8'h00;
			low_r <= 8'h00;
			last_r <= 8'h00;
			data_r <= 8'h00;
			prot_r <= 8'hFF;
			op_r <= FSPS_OP_ENTER;
			big_r <= 1'b0;
		end else if (ce_i && wb_hit && wb_we_i && wb_sel_i && !wb_ack_o && !busy_o) begin
			case (wb_adr_i)
				`FSPS_WB_CTRL: begin
					op_r <= fsps_op_t'(wb_dat_i[`FSPS_CTRL_OP_MSB:`FSPS_CTRL_OP_LSB]);
					big_r <= wb_dat_i[`FSPS_CTRL_BIG_BIT];
				end
				`FSPS_WB_BLOCK: block_r <= wb_dat_i & `FSPS_HIGH_NIBBLE_MASK;
				`FSPS_WB_LOW: low_r <= wb_dat_i;
				`FSPS_WB_LAST: last_r <= wb_dat_i;
				`FSPS_WB_DATA: data_r <= wb_dat_i;
				`FSPS_WB_PROT: prot_r <= wb_dat_i;
				default: ;
			endcase
		end
	end

	// Wishbone read data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 8'h00;
		end else if (ce_i && wb_hit && !wb_ack_o) begin
			case (wb_adr_i)
				`FSPS_WB_CTRL: wb_dat_o <= {3'b000, big_r, op_r, 1'b0};
				`FSPS_WB_STATUS: wb_dat_o <= {4'h0, prot_hit_r, seq_fail_r, done_r, busy_o};
				`FSPS_WB_BLOCK: wb_dat_o <= block_r;
				`FSPS_WB_LOW: wb_dat_o <= low_r;
				`FSPS_WB_LAST: wb_dat_o <= last_r;
				`FSPS_WB_DATA: wb_dat_o <= data_r;
				`FSPS_WB_PROT: wb_dat_o <= prot_r;
				`FSPS_WB_RESULT: wb_dat_o <= result_r;
				default: wb_dat_o <= 8'h00;
			endcase
		end
	end

	// Device access request for each state
	always_comb begin
		acc_req = 1'b1;
		acc_we = 1'b1;
		acc_addr = `FSPS_DEV_STATUS_ADDR;
		acc_wdata = `FSPS_ZERO;
		case (state_r)
			FSPS_MASK0: begin
				acc_addr = `FSPS_DEV_MASK0_ADDR;
				acc_wdata = `FSPS_ALL_ONES;
			end
			FSPS_MASK1: begin
				acc_addr = `FSPS_DEV_MASK1_ADDR;
				acc_wdata = `FSPS_ALL_ONES;
			end
			FSPS_CLR, FSPS_CLR2: acc_wdata = `FSPS_ZERO;
			FSPS_KEY: begin
				acc_addr = `FSPS_DEV_KEY_ADDR;
				acc_wdata = `FSPS_KEY_VAL;
			end
			FSPS_MODE1, FSPS_MODE2: begin
				acc_addr = `FSPS_DEV_MODE_ADDR;
				acc_wdata = mode_val;
			end
			FSPS_MODEC: begin
				acc_addr = `FSPS_DEV_MODE_ADDR;
				acc_wdata = ~mode_val;
			end
			FSPS_CHECK, FSPS_READRES: acc_we = 1'b0;
			FSPS_RESTORE0: acc_addr = `FSPS_DEV_MASK0_ADDR;
			FSPS_RESTORE1: acc_addr = `FSPS_DEV_MASK1_ADDR;
			FSPS_CMD: begin
				acc_addr = `FSPS_DEV_CMD_ADDR;
				case (op_r)
					FSPS_OP_ERASE: acc_wdata = `FSPS_CMD_ERASE;
					FSPS_OP_BLANK: acc_wdata = `FSPS_CMD_BLANK;
					FSPS_OP_WRITE: acc_wdata = `FSPS_CMD_WRITE;
					default: acc_wdata = `FSPS_CMD_VERIFY;
				endcase
			end
			FSPS_PTRH: begin
				acc_addr = `FSPS_DEV_PTRH_ADDR;
				acc_wdata = block_r;
			end
			FSPS_PTRL: begin
				acc_addr = `FSPS_DEV_PTRL_ADDR;
				acc_wdata = (op_r == FSPS_OP_WRITE || op_r == FSPS_OP_VERIFY) ? low_r
					: `FSPS_ZERO;
			end
			FSPS_CMPH: begin
				acc_addr = `FSPS_DEV_CMPH_ADDR;
				acc_wdata = block_r;
			end
			FSPS_CMPL: begin
				acc_addr = `FSPS_DEV_CMPL_ADDR;
				case (op_r)
					FSPS_OP_ERASE: acc_wdata = `FSPS_ZERO;
					FSPS_OP_BLANK: acc_wdata = `FSPS_ALL_ONES;
					default: acc_wdata = last_r;
				endcase
			end
			FSPS_WBUF: begin
				acc_addr = `FSPS_DEV_WBUF_ADDR;
				acc_wdata = data_r;
			end
			default: acc_req = 1'b0;
		endcase
	end

	fsps_devport u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.req_i(acc_req),
		.we_i(acc_we),
		.addr_i(acc_addr),
		.wdata_i(acc_wdata),
		.done_o(acc_done),
		.rdata_o(acc_rdata),
		.dev_we_o(dev_we_o),
		.dev_re_o(dev_re_o),
		.dev_addr_o(dev_addr_o),
		.dev_wdata_o(dev_wdata_o),
		.dev_rdata_i(dev_rdata_i)
	);

	// Sequencer: mode switch with retry, or command setup and halt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= FSPS_IDLE;
			retry_r <= 8'h00;
			result_r <= 8'h00;
			seq_fail_r <= 1'b0;
			prot_hit_r <= 1'b0;
			done_r <= 1'b0;
			halt_req_o <= 1'b0;
		end else if (ce_i) begin
			case (state_r)
				FSPS_IDLE: begin
					if (go) begin
						done_r <= 1'b0;
						seq_fail_r <= 1'b0;
						prot_hit_r <= 1'b0;
						retry_r <= 8'h00;
						// Op and variant arrive with this very write, so take them off the bus
						case (fsps_op_t'(wb_dat_i[`FSPS_CTRL_OP_MSB:`FSPS_CTRL_OP_LSB]))
							FSPS_OP_ENTER: state_r <= FSPS_MASK0;
							FSPS_OP_LEAVE: state_r <= FSPS_CLR;
							default: begin
								if (blk_protected(prot_r, block_r,
									wb_dat_i[`FSPS_CTRL_BIG_BIT])) begin
									prot_hit_r <= 1'b1;
									state_r <= FSPS_DONE;
								end else begin
									state_r <= FSPS_CMD;
								end
							end
						endcase
					end
				end
				FSPS_MASK0: if (acc_done) state_r <= FSPS_MASK1;
				FSPS_MASK1: if (acc_done) state_r <= FSPS_CLR;
				FSPS_CLR: if (acc_done) state_r <= FSPS_KEY;
				FSPS_KEY: if (acc_done) state_r <= FSPS_MODE1;
				FSPS_MODE1: if (acc_done) state_r <= FSPS_MODEC;
				FSPS_MODEC: if (acc_done) state_r <= FSPS_MODE2;
				FSPS_MODE2: if (acc_done) state_r <= FSPS_CHECK;
				FSPS_CHECK: begin
					if (acc_done) begin
						result_r <= acc_rdata;
						if (acc_rdata[`FSPS_STAT_SEQ_BIT]) begin
							if (retry_r >= 8'(MAX_RETRY - 1)) begin
								seq_fail_r <= 1'b1;
								state_r <= FSPS_DONE;
							end else begin
								retry_r <= retry_r + 8'h01;
								state_r <= FSPS_CLR;
							end
						end else if (op_r == FSPS_OP_LEAVE) begin
							state_r <= FSPS_RESTORE0;
						end else begin
							state_r <= FSPS_DONE;
						end
					end
				end
				FSPS_RESTORE0: if (acc_done) state_r <= FSPS_RESTORE1;
				FSPS_RESTORE1: if (acc_done) state_r <= FSPS_DONE;
				FSPS_CMD: if (acc_done) state_r <= FSPS_PTRH;
				FSPS_PTRH: if (acc_done) state_r <= FSPS_PTRL;
				FSPS_PTRL: if (acc_done) state_r <= FSPS_CMPH;
				FSPS_CMPH: if (acc_done) state_r <= FSPS_CMPL;
				FSPS_CMPL: begin
					if (acc_done) begin
						state_r <= (op_r == FSPS_OP_WRITE) ? FSPS_WBUF : FSPS_CLR2;
					end
				end
				FSPS_WBUF: if (acc_done) state_r <= FSPS_CLR2;
				FSPS_CLR2: begin
					if (acc_done) begin
						halt_req_o <= 1'b1;
						state_r <= FSPS_HALT;
					end
				end
				FSPS_HALT: begin
					halt_req_o <= 1'b0;
					state_r <= FSPS_WAITDONE;
				end
				FSPS_WAITDONE: if (halt_done_i) state_r <= FSPS_READRES;
				FSPS_READRES: begin
					if (acc_done) begin
						result_r <= acc_rdata;
						prot_hit_r <= acc_rdata[`FSPS_STAT_WE_BIT];
						state_r <= FSPS_DONE;
					end
				end
				FSPS_DONE: begin
					done_r <= 1'b1;
					state_r <= FSPS_IDLE;
				end
				default: state_r <= FSPS_IDLE;
			endcase
		end
	end
endmodule // fsps_host

/* testbench/fsps_host_monitor.sv */
// Checker for the host controller's bus handshake and device-port sequencing
`timescale 1ns/1ps
`include "fsps_defs.svh"
module fsps_host_monitor #(
	parameter int MAX_RETRY = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic dev_we_o,
	input wire logic dev_re_o,
	input wire logic [15:0] dev_addr_o,
	input wire logic [7:0] dev_wdata_o,
	input wire logic halt_req_o,
	input wire logic busy_o
);
	logic [7:0] ptrh_r;
	logic [7:0] cmd_r;
	logic clr_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Remember the last pointer, command and status clear sent to the device
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptrh_r <= 8'h00;
			cmd_r <= 8'h00;
			clr_r <= 1'b0;
		end else begin
			if (dev_we_o && dev_addr_o == `FSPS_DEV_PTRH_ADDR) ptrh_r <= dev_wdata_o;
			if (dev_we_o && dev_addr_o == `FSPS_DEV_CMD_ADDR) cmd_r <= dev_wdata_o;
			if (dev_we_o && dev_addr_o == `FSPS_DEV_STATUS_ADDR) clr_r <= 1'b1;
			else if (halt_req_o) clr_r <= 1'b0;
		end
	end
	sequence key_wr;
		dev_we_o && dev_addr_o == `FSPS_DEV_KEY_ADDR && dev_wdata_o == `FSPS_KEY_VAL;
	endsequence
	sequence mode_wr;
		dev_we_o && dev_addr_o == `FSPS_DEV_MODE_ADDR;
	endsequence
	ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("ack did not follow request");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	strobe_pulse_a: assert property (dev_we_o || dev_re_o |=> !dev_we_o && !dev_re_o)
		else $error("device strobes too close");
	strobe_excl_a: assert property (!(dev_we_o && dev_re_o))
		else $error("read and write together");
	halt_busy_a: assert property (halt_req_o |-> busy_o ##1 !halt_req_o)
		else $error("halt request not a busy pulse");
	halt_clear_a: assert property (halt_req_o |-> clr_r)
		else $error("halt without status clear");
	nibble_zero_a: assert property (dev_we_o && (dev_addr_o == `FSPS_DEV_PTRH_ADDR
		|| dev_addr_o == `FSPS_DEV_CMPH_ADDR) |-> dev_wdata_o[7:4] == 4'h0)
		else $error("block number upper nibble set");
	cmph_match_a: assert property (dev_we_o && dev_addr_o == `FSPS_DEV_CMPH_ADDR
		|-> dev_wdata_o == ptrh_r)
		else $error("compare block differs from pointer");
	cmpl_fixed_a: assert property (dev_we_o && dev_addr_o == `FSPS_DEV_CMPL_ADDR
		&& (cmd_r == `FSPS_CMD_ERASE || cmd_r == `FSPS_CMD_BLANK)
		|-> dev_wdata_o == (cmd_r == `FSPS_CMD_ERASE ? 8'h00 : 8'hFF))
		else $error("low compare wrong for erase or blank");
	unlock_next_a: assert property (key_wr |=> !dev_we_o until mode_wr)
		else $error("write between key and mode");
	unlock_bound_a: assert property (key_wr |-> ##[1:8] mode_wr)
		else $error("mode write missing after key");
endmodule // fsps_host_monitor

bind fsps_host fsps_host_monitor #(.MAX_RETRY(MAX_RETRY)) u_fsps_host_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .dev_we_o(dev_we_o), .dev_re_o(dev_re_o), .dev_addr_o(dev_addr_o),
	.dev_wdata_o(dev_wdata_o), .halt_req_o(halt_req_o), .busy_o(busy_o));

/* testbench/fsps_dev_model.sv */
// Behavioural flash unit: registers, unlock tracker, protection and halt timing
`timescale 1ns/1ps
`include "fsps_defs.svh"
module fsps_dev_model #(
	parameter int DELAY = 30
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic dev_we_i,
	input wire logic dev_re_i,
	input wire logic [15:0] dev_addr_i,
	input wire logic [7:0] dev_wdata_i,
	output logic [7:0] dev_rdata_o,
	input wire logic halt_req_i,
	output logic halt_done_o,
	input wire logic [7:0] prot_i,
	input wire logic big_i,
	input wire logic [3:0] fail_i
);
	logic [7:0] stat_r, mode_r, cmd_r, ptrh_r, ptrl_r, cmph_r, cmpl_r, wbuf_r, msk0_r, msk1_r;
	logic [7:0] val_r;
	logic [7:0] cnt_r;
	logic [7:0] junk_r;
	logic [1:0] seq_r;
	logic [3:0] fails_r;
	logic [4:0] code;
	logic [4:0] top;
	logic ok;
	logic prot;
	int runs;
	// Protect select decode; prohibited codes guard every block
	assign code = prot_i[6:2];
	assign ok = big_i ? (code >= 5'h08 && code <= 5'h0F) : (code >= 5'h0C && code <= 5'h0F);
	assign top = big_i ? 5'(15 - 2 * (int'(code) - 8)) : 5'(7 - 2 * (int'(code) - 12));
	assign prot = mode_r[0] && code != 5'h1F && (!ok || {3'h0, top} >= ptrh_r);
	// Register file, unlock tracker and operation start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{stat_r, mode_r, cmd_r, ptrh_r, ptrl_r} <= '0;
			{cmph_r, cmpl_r, wbuf_r, msk0_r, msk1_r, val_r} <= '0;
			seq_r <= 2'h0;
			fails_r <= 4'h0;
			runs <= 0;
		end else begin
			if (fail_i == 4'h0) fails_r <= 4'h0;
			if (halt_req_i && prot) stat_r[2] <= 1'b1;
			else if (halt_req_i) runs <= runs + 1;
			if (dev_we_i) begin
				case (dev_addr_i)
					`FSPS_DEV_KEY_ADDR: seq_r <= dev_wdata_i == `FSPS_KEY_VAL ? 2'h1 : 2'h0;
					`FSPS_DEV_STATUS_ADDR: stat_r <= dev_wdata_i & 8'h07;
					`FSPS_DEV_CMD_ADDR: cmd_r <= dev_wdata_i;
					`FSPS_DEV_PTRH_ADDR: ptrh_r <= dev_wdata_i;
					`FSPS_DEV_PTRL_ADDR: ptrl_r <= dev_wdata_i;
					`FSPS_DEV_CMPH_ADDR: cmph_r <= dev_wdata_i;
					`FSPS_DEV_CMPL_ADDR: cmpl_r <= dev_wdata_i;
					`FSPS_DEV_WBUF_ADDR: wbuf_r <= dev_wdata_i;
					`FSPS_DEV_MASK0_ADDR: msk0_r <= dev_wdata_i;
					`FSPS_DEV_MASK1_ADDR: msk1_r <= dev_wdata_i;
					`FSPS_DEV_MODE_ADDR: begin
						if (seq_r == 2'h1) val_r <= dev_wdata_i;
						if (seq_r == 2'h0 || (seq_r == 2'h2 && dev_wdata_i != ~val_r)
							|| (seq_r == 2'h3 && dev_wdata_i != val_r)) begin
							stat_r[0] <= 1'b1;
							seq_r <= 2'h0;
						end else if (seq_r == 2'h3 && fails_r < fail_i) begin
							fails_r <= fails_r + 4'h1; // Commanded refusal of a good commit
							stat_r[0] <= 1'b1;
							seq_r <= 2'h0;
						end else if (seq_r == 2'h3) begin
							mode_r <= dev_wdata_i;
							seq_r <= 2'h0;
						end else seq_r <= seq_r + 2'h1;
					end
					default: ;
				endcase
				if (seq_r != 2'h0 && dev_addr_i != `FSPS_DEV_MODE_ADDR) begin
					stat_r[0] <= 1'b1;
					seq_r <= 2'h0;
				end
			end
		end
	end
	// Read data stands while the read strobe is high; the bus churns otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) junk_r <= 8'h00;
		else junk_r <= ~junk_r;
	end
	assign dev_rdata_o = !dev_re_i ? junk_r
		: (dev_addr_i == `FSPS_DEV_STATUS_ADDR ? stat_r : mode_r);
	// Slow operation timer after the halt request
	always_ff @(posedge clk_i) begin
		if (rst_i) cnt_r <= 8'h00;
		else if (halt_req_i) cnt_r <= 8'(DELAY);
		else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
		halt_done_o <= !rst_i && cnt_r == 8'h01;
	end
endmodule // fsps_dev_model

/* testbench/tb_fsps_host.sv */
// Self-checking bench for the flash self-programming host controller
`timescale 1ns/1ps
`include "fsps_defs.svh"
module tb_fsps_host;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, big = 1'b0;
	logic [3:0] adr = 4'h0, fail = 4'h0;
	logic [7:0] dat = 8'h00, prot = 8'hFF, rd, dq, dwd, drd;
	logic ack, dwe, dre, hreq, hdone, busy;
	logic [15:0] dadr;
	int failures = 0, cmp_count = 0, cycles = 0, n;
	always #5 clk_i = ~clk_i;
	fsps_host #(.MAX_RETRY(2)) u_fsps_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(1'b1), .wb_dat_o(dq), .wb_ack_o(ack), .dev_we_o(dwe), .dev_re_o(dre),
		.dev_addr_o(dadr), .dev_wdata_o(dwd), .dev_rdata_i(drd), .halt_req_o(hreq),
		.halt_done_i(hdone), .busy_o(busy));
	fsps_dev_model u_fsps_dev_model (.clk_i(clk_i), .rst_i(rst_i), .dev_we_i(dwe),
		.dev_re_i(dre), .dev_addr_i(dadr), .dev_wdata_i(dwd), .dev_rdata_o(drd),
		.halt_req_i(hreq), .halt_done_o(hdone), .prot_i(prot), .big_i(big), .fail_i(fail));
	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[FAIL] t=%0t timeout exp=%h got=%h", $time, 1'b0, 1'b1);
			print_verdict;
		end
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// One classic Wishbone cycle; read data taken at the ack edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dq;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	// Start an operation and poll status until idle
	task automatic run(input logic [2:0] op, input logic [7:0] m, input logic [7:0] e);
		wb(1'b1, `FSPS_WB_CTRL, {3'h0, big, op, 1'b1});
		rd = 8'h01;
		while (rd[0] !== 1'b0) wb(1'b0, `FSPS_WB_STATUS, 8'h00);
		chk(e, rd & m);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(8'h00, u_fsps_dev_model.cmph_r);
		chk(8'h00, u_fsps_dev_model.cmpl_r);
		chk(8'h00, u_fsps_dev_model.wbuf_r);
		wb(1'b1, 4'h9, 8'h55);
		wb(1'b0, 4'h9, 8'h00);
		chk(8'h00, rd);
		$display("test reset done");
		fail <= 4'h1;
		run(3'h0, 8'h0F, 8'h02);
		chk(8'h01, u_fsps_dev_model.mode_r);
		chk(8'hFF, u_fsps_dev_model.msk0_r);
		chk(8'hFF, u_fsps_dev_model.msk1_r);
		fail <= 4'h0;
		$display("test enter done");
		wb(1'b1, `FSPS_WB_BLOCK, 8'hF3);
		wb(1'b0, `FSPS_WB_BLOCK, 8'h00);
		chk(8'h03, rd);
		run(3'h2, 8'h0F, 8'h02);
		chk(`FSPS_CMD_ERASE, u_fsps_dev_model.cmd_r);
		chk(8'h03, u_fsps_dev_model.cmph_r);
		chk(8'h00, u_fsps_dev_model.cmpl_r);
		run(3'h3, 8'h0F, 8'h02);
		chk(`FSPS_CMD_BLANK, u_fsps_dev_model.cmd_r);
		chk(8'hFF, u_fsps_dev_model.cmpl_r);
		wb(1'b1, `FSPS_WB_DATA, 8'h5A);
		wb(1'b1, `FSPS_WB_LOW, 8'h10);
		run(3'h4, 8'h0F, 8'h02);
		chk(`FSPS_CMD_WRITE, u_fsps_dev_model.cmd_r);
		chk(8'h5A, u_fsps_dev_model.wbuf_r);
		chk(8'h10, u_fsps_dev_model.ptrl_r);
		wb(1'b1, `FSPS_WB_LAST, 8'h7F);
		run(3'h5, 8'h0F, 8'h02);
		chk(`FSPS_CMD_VERIFY, u_fsps_dev_model.cmd_r);
		chk(8'h7F, u_fsps_dev_model.cmpl_r);
		$display("test commands done");
		prot <= 8'hBF;
		wb(1'b1, `FSPS_WB_PROT, 8'hBF);
		wb(1'b1, `FSPS_WB_BLOCK, 8'h01);
		n = u_fsps_dev_model.runs;
		run(3'h2, 8'h09, 8'h08);
		big <= 1'b1;
		wb(1'b1, `FSPS_WB_BLOCK, 8'h02);
		run(3'h2, 8'h09, 8'h00);
		prot <= 8'hA3;
		wb(1'b1, `FSPS_WB_PROT, 8'hA3);
		wb(1'b1, `FSPS_WB_BLOCK, 8'h09);
		run(3'h2, 8'h09, 8'h08);
		prot <= 8'h83;
		wb(1'b1, `FSPS_WB_PROT, 8'h83);
		run(3'h3, 8'h09, 8'h08);
		chk(8'(n + 1), 8'(u_fsps_dev_model.runs));
		chk(8'h00, u_fsps_dev_model.stat_r & 8'h04);
		wb(1'b1, `FSPS_WB_PROT, 8'hFF);
		run(3'h2, 8'h09, 8'h08);
		chk(8'(n + 1), 8'(u_fsps_dev_model.runs));
		$display("test protect done");
		run(3'h1, 8'h0F, 8'h02);
		chk(8'h00, u_fsps_dev_model.mode_r);
		chk(8'h00, u_fsps_dev_model.msk0_r);
		fail <= 4'hF;
		run(3'h0, 8'h05, 8'h04);
		chk(8'h00, u_fsps_dev_model.mode_r);
		$display("test leave and retry done");
		print_verdict;
	end
endmodule // tb_fsps_host
